// *** verilog/iowm_pkg.sv ***
package iowm_pkg;
   // register indexes, per socket
   localparam logic [5:0] IOWM_W0_START_LOW = 6'h08;
   localparam logic [5:0] IOWM_W0_START_HIGH = 6'h09;
   localparam logic [5:0] IOWM_W0_END_LOW = 6'h0a;
   localparam logic [5:0] IOWM_W0_END_HIGH = 6'h0b;
   localparam logic [5:0] IOWM_W1_START_LOW = 6'h0c;
   localparam logic [5:0] IOWM_W1_START_HIGH = 6'h0d;
   localparam logic [5:0] IOWM_W1_END_LOW = 6'h0e;
   localparam logic [5:0] IOWM_W1_END_HIGH = 6'h0f;
   localparam logic [5:0] IOWM_W0_OFFSET_LOW = 6'h36;
   localparam logic [5:0] IOWM_W0_OFFSET_HIGH = 6'h37;
   localparam logic [5:0] IOWM_W1_OFFSET_LOW = 6'h38;
   localparam logic [5:0] IOWM_W1_OFFSET_HIGH = 6'h39;
   // field layout and reset values
   localparam int IOWM_OFFSET_ZERO_BIT = 0;
   localparam logic [7:0] IOWM_REG_RESET = 8'h00;
   localparam logic [7:0] IOWM_OFFSET_LOW_MASK = 8'hfe;
   localparam logic [7:0] IOWM_UNMAPPED_READ = 8'h00;
   // lookup state
   typedef enum logic [1:0] {
      IOWM_IDLE = 2'b01,
      IOWM_HIT = 2'b10
   } iowm_state_e;
endpackage

// *** verilog/iowm_window.sv ***
`timescale 1ns/1ps
// one window: range compare and offset add
module iowm_window
   import iowm_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // window setup
   input wire logic [ADDR_W-1:0] start_addr,
   input wire logic [ADDR_W-1:0] end_addr,
   input wire logic [ADDR_W-1:0] offset,
   // host address
   input wire logic [ADDR_W-1:0] host_addr,
   // result
   output logic hit,
   output logic [ADDR_W-1:0] card_addr
);
   // refuse widths the compare and add cannot serve
   if (ADDR_W < 2) begin : g_width_check
      $error("address width too small");
   end
   // inclusive on both ends
   assign hit = (host_addr >= start_addr) && (host_addr <= end_addr); // [R1]
   // carry out of the top bit is dropped on purpose
   assign card_addr = ADDR_W'(host_addr + offset); // [R5] [R10]
endmodule // iowm_window

// *** verilog/iowm_regs.sv ***
`timescale 1ns/1ps
// per-socket register file for both I/O windows
module iowm_regs
   import iowm_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // window setup
   output logic [15:0] start0,
   output logic [15:0] end0,
   output logic [15:0] offset0,
   output logic [15:0] start1,
   output logic [15:0] end1,
   output logic [15:0] offset1
);
   logic [7:0] regs_r [0:11];
   logic [7:0] rdata_r;
   logic [3:0] sel;
   logic sel_ok;
   logic [7:0] wmasked;

   // index decode into slot
   always_comb begin
      sel = 4'h0;
      sel_ok = 1'b1;
      case (reg_addr)
         IOWM_W0_START_LOW: sel = 4'h0; // [R9]
         IOWM_W0_START_HIGH: sel = 4'h1; // [R9]
         IOWM_W0_END_LOW: sel = 4'h2; // [R2]
         IOWM_W0_END_HIGH: sel = 4'h3; // [R3] [R4]
         IOWM_W1_START_LOW: sel = 4'h4; // [R9]
         IOWM_W1_START_HIGH: sel = 4'h5; // [R9]
         IOWM_W1_END_LOW: sel = 4'h6; // [R2]
         IOWM_W1_END_HIGH: sel = 4'h7; // [R3] [R4]
         IOWM_W0_OFFSET_LOW: sel = 4'h8; // [R7]
         IOWM_W0_OFFSET_HIGH: sel = 4'h9; // [R8]
         IOWM_W1_OFFSET_LOW: sel = 4'ha; // [R7]
         IOWM_W1_OFFSET_HIGH: sel = 4'hb; // [R8]
         default: sel_ok = 1'b0;
      endcase
   end

   // bit 0 of offset low is forced to zero, so the offset stays even even if software errs
   assign wmasked = (sel == 4'h8 || sel == 4'ha) ? (reg_wdata & IOWM_OFFSET_LOW_MASK) : reg_wdata; // [R6]

   // storage, cleared on reset
   always_ff @(posedge clock) begin
      if (!resetn) begin
         for (int i = 0; i < 12; i++) begin
            regs_r[i] <= IOWM_REG_RESET; // [R11]
         end
      end else if (reg_write && sel_ok) begin
         regs_r[sel] <= wmasked; // [R11]
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_r <= IOWM_UNMAPPED_READ;
      end else if (reg_read && sel_ok) begin
         rdata_r <= regs_r[sel];
      end else begin
         rdata_r <= IOWM_UNMAPPED_READ;
      end
   end
   assign reg_rdata = rdata_r;

   // assembled window fields
   assign start0 = {regs_r[1], regs_r[0]};
   assign end0 = {regs_r[3], regs_r[2]}; // [R2] [R3]
   assign offset0 = {regs_r[9], regs_r[8]}; // [R8]
   assign start1 = {regs_r[5], regs_r[4]};
   assign end1 = {regs_r[7], regs_r[6]}; // [R2] [R3]
   assign offset1 = {regs_r[11], regs_r[10]}; // [R8]
endmodule // iowm_regs

// *** verilog/iowm_top.sv ***
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
//
// Summary of operation
// R1 - map only when start <= address <= end
// R2 - end low holds end bits 7:0
// R3 - end high holds end bits 15:8
// R4 - end high at 0Bh and 0Fh
// R5 - card address is host plus offset
// R6 - offset low bits 7:1, bit 0 zero
// R7 - offset low at 36h and 38h
// R8 - offset high bits 15:8, 37h/39h
// R9 - start bytes at 08h/0Ch, 09h/0Dh
// R10 - 16-bit sum, carry dropped
// R11 - all registers read/write, reset to zero
module iowm_top
   import iowm_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // host i/o access request
   input wire logic host_io_req,
   input wire logic [15:0] host_io_addr,
   // card side result
   output logic card_io_valid,
   output logic card_io_window,
   output logic [15:0] card_io_addr
);
   logic [15:0] start0;
   logic [15:0] end0;
   logic [15:0] offset0;
   logic [15:0] start1;
   logic [15:0] end1;
   logic [15:0] offset1;
   logic hit0;
   logic hit1;
   logic [15:0] card0;
   logic [15:0] card1;
   logic valid_r;
   logic valid_nxt;
   logic window_r;
   logic window_nxt;
   logic [15:0] addr_r;
   logic [15:0] addr_nxt;
   iowm_state_e state_r;
   iowm_state_e state_nxt;

   iowm_regs u_regs (
      .clock(clock),
      .resetn(resetn),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_write(reg_write),
      .reg_read(reg_read),
      .reg_rdata(reg_rdata),
      .start0(start0),
      .end0(end0),
      .offset0(offset0),
      .start1(start1),
      .end1(end1),
      .offset1(offset1)
   );

   iowm_window #(.ADDR_W(16)) u_win0 (
      .start_addr(start0),
      .end_addr(end0),
      .offset(offset0),
      .host_addr(host_io_addr),
      .hit(hit0),
      .card_addr(card0)
   );

   iowm_window #(.ADDR_W(16)) u_win1 (
      .start_addr(start1),
      .end_addr(end1),
      .offset(offset1),
      .host_addr(host_io_addr),
      .hit(hit1),
      .card_addr(card1)
   );

   // window 0 wins if software lets windows overlap
   always_comb begin
      valid_nxt = 1'b0;
      window_nxt = window_r;
      addr_nxt = addr_r;
      state_nxt = IOWM_IDLE;
      case (state_r)
         IOWM_IDLE, IOWM_HIT: begin
            if (host_io_req && hit0) begin
               valid_nxt = 1'b1; // [R1]
               window_nxt = 1'b0;
               addr_nxt = card0; // [R5] [R10]
               state_nxt = IOWM_HIT;
            end else if (host_io_req && hit1) begin
               valid_nxt = 1'b1; // [R1]
               window_nxt = 1'b1;
               addr_nxt = card1; // [R5] [R10]
               state_nxt = IOWM_HIT;
            end
         end
         default: state_nxt = IOWM_IDLE;
      endcase
   end

   // result registers, one cycle after the request
   always_ff @(posedge clock) begin
      if (!resetn) begin
         state_r <= IOWM_IDLE;
         valid_r <= 1'b0;
         window_r <= 1'b0;
         addr_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         valid_r <= valid_nxt;
         window_r <= window_nxt;
         addr_r <= addr_nxt;
      end
   end

   assign card_io_valid = valid_r;
   assign card_io_window = window_r;
   assign card_io_addr = addr_r;
endmodule // iowm_top

// *** verif/iowm_sva.sv ***
`timescale 1ns/1ps
// port checks; no shadow is kept, so write-then-read pairs carry the data
module iowm_sva (
   // all top ports
   input logic clock, resetn, reg_write, reg_read, host_io_req, card_io_valid, card_io_window,
   input logic [5:0] reg_addr,
   input logic [7:0] reg_wdata, reg_rdata,
   input logic [15:0] host_io_addr, card_io_addr
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // index groups: whole-byte registers and offset low bytes
   wire full = reg_addr inside {[6'h08:6'h0f], 6'h37, 6'h39};
   wire low = reg_addr inside {6'h36, 6'h38};
   rd_idle_a: assert property (!reg_read |=> reg_rdata == 8'h00) else $error("stale read");
   rd_unmap_a: assert property (reg_read && !full && !low |=> reg_rdata == 8'h00)
      else $error("unmapped read");
   even_off_a: assert property (reg_read && low |=> !reg_rdata[0]) else $error("odd offset");
   wr_full_a: assert property (reg_write ##1 reg_read && full && $stable(reg_addr)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("byte lost");
   wr_low_a: assert property (reg_write ##1 reg_read && low && $stable(reg_addr)
      |=> reg_rdata == ($past(reg_wdata, 2) & 8'hfe)) else $error("offset lost");
   no_req_a: assert property (!host_io_req |=> !card_io_valid) else $error("valid alone");
   miss_hold_a: assert property (!card_io_valid |-> $stable(card_io_addr) && $stable(card_io_window))
      else $error("moved");
   reset_zero_a: assert property ($rose(resetn) |-> reg_rdata == 8'h00 && card_io_addr == 16'h0000)
      else $error("reset value");
   cover property (card_io_valid && card_io_window);
   cover property (card_io_valid && !card_io_window);
   cover property (reg_write ##1 reg_read);
endmodule // iowm_sva
bind iowm_top iowm_sva u_sva (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
   .host_io_req, .host_io_addr, .card_io_valid, .card_io_window, .card_io_addr);

// *** verif/iowm_host.sv ***
`timescale 1ns/1ps
// host i/o master: one request cycle per call
module iowm_host (
   // host side
   input logic clock,
   output logic host_io_req = 1'b0,
   output logic [15:0] host_io_addr = 16'h0000
);
   // call after a rising edge; a released address shows its inverse
   task automatic access(input logic [15:0] a);
      host_io_req <= 1'b1;
      host_io_addr <= a;
      @(posedge clock);
      host_io_req <= 1'b0;
      host_io_addr <= ~a;
   endtask
endmodule // iowm_host

// *** verif/iowm_top_bench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, b); end end
// register and lookup tests
module iowm_top_bench;
   logic clock = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata;
   logic host_io_req, card_io_valid, card_io_window;
   logic [15:0] host_io_addr, card_io_addr;
   int error_cnt = 0, checks = 0;
   // mapped indexes and values: window 0 1000-10ff, window 1 3000-3010
   logic [5:0] idx [12] = '{6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h36, 6'h37, 6'h38, 6'h39};
   logic [7:0] val [12] = '{8'h00, 8'h10, 8'hff, 8'h10, 8'h00, 8'h30, 8'h10, 8'h30, 8'h02, 8'h20, 8'h00, 8'hf0};
   // host address, then valid, window and card address
   logic [33:0] lk [5] = '{{16'h0fff, 18'h0_0000}, {16'h1000, 18'h2_3002}, {16'h10ff, 18'h2_3101},
      {16'h1100, 18'h0_3101}, {16'h3010, 18'h3_2010}};
   iowm_top u_dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .host_io_req, .host_io_addr, .card_io_valid, .card_io_window, .card_io_addr);
   iowm_host u_host (.clock, .host_io_req, .host_io_addr);
   always #50 clock = ~clock;
   // write strobe stays up so a read may follow with no gap
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      reg_write <= 1'b0;
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      `CHK(reg_rdata, e)
      @(posedge clock);
   endtask
   task automatic look(input logic [15:0] a, input logic [17:0] e);
      u_host.access(a);
      @(negedge clock);
      `CHK({card_io_valid, card_io_window, card_io_addr}, e)
      @(posedge clock);
   endtask
   task automatic complete_run();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog, about ten times the test length
   initial begin
      #100000;
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (10) @(posedge clock);
      resetn <= 1'b1;
      foreach (idx[i]) rd(idx[i], 8'h00);
      wr(6'h3f, 8'hff);
      rd(6'h3f, 8'h00);
      foreach (idx[i]) begin
         wr(idx[i], val[i]);
         rd(idx[i], idx[i] inside {6'h36, 6'h38} ? val[i] & 8'hfe : val[i]);
      end
      foreach (lk[i]) look(lk[i][33:18], lk[i][17:0]);
      wr(6'h0b, 8'h0f);
      rd(6'h0b, 8'h0f);
      look(16'h1000, 18'h1_2010);
      complete_run();
   end
endmodule // iowm_top_bench
